// ---- hdl/nco_preset_freq_phase.sv ----
/*
 * Numerically controlled oscillator preset set for two down-converter channels.
 * Holds four tuning words and phase offsets per channel, runs one phase
 * accumulator per channel on the sample clock and adds the active offset.
 * Assumes preset selection, mode, divisor and arm bit come from logic on mclk,
 * and that sysref arrives asynchronously from a pin.
 */
`include "nco_defines.svh"

module nco_preset_freq_phase #(
	parameter int PRESETS = 4,
	parameter int PHASE_W = 16,
	parameter int DIV_W = 16
) (
	input wire logic mclk, // Sample clock, 20 MHz.
	input wire logic reset_n, // Asynchronous reset, active low.
	input wire logic [11:0] reg_addr, // Register byte address.
	input wire logic [31:0] reg_wdata, // Register write data.
	input wire logic reg_wr, // Register write strobe.
	input wire logic reg_rd, // Register read strobe.
	output logic [31:0] reg_rdata, // Read data, the cycle after reg_rd.
	input wire logic interleave_mode, // High in interleaved single-channel mode.
	input wire logic [$clog2(PRESETS)-1:0] preset_sel_a, // Active preset, channel A.
	input wire logic [$clog2(PRESETS)-1:0] preset_sel_b, // Active preset, channel B.
	input wire logic [DIV_W-1:0] reference_divisor, // Divisor, zero disables it.
	input wire logic sync_arm_bit, // Arm level from the sync control register.
	input wire logic sysref, // Asynchronous sysref pin.
	output logic [31:0] phase_a, // Channel A oscillator phase.
	output logic [31:0] phase_b, // Channel B oscillator phase.
	output logic sync_armed, // High while armed and waiting for sysref.
	output logic sync_done // One-cycle pulse when sysref initialized the phase.
);

	localparam int SW = $clog2(PRESETS);
	localparam int CHANNELS = 2;

	// ****************************************************************
	// Register port decode
	// ****************************************************************
	logic hit_a;
	logic hit_b;
	logic word_aligned;
	logic [SW:0] word_index;
	logic [31:0] rd_data_a;
	logic [31:0] rd_data_b;

	assign word_aligned = (reg_addr[1:0] == 2'b00);
	assign hit_a = word_aligned && ((reg_addr & ~`NCO_BANK_MASK) == `NCO_BANK_A_BASE);
	assign hit_b = word_aligned && ((reg_addr & ~`NCO_BANK_MASK) == `NCO_BANK_B_BASE);
	assign word_index = reg_addr[SW+2:2];

	// ****************************************************************
	// Preset banks
	// ****************************************************************
	logic [31:0] bank_freq [CHANNELS];
	logic [PHASE_W-1:0] bank_phase [CHANNELS];
	logic [SW-1:0] sel_b_eff;

	assign sel_b_eff = interleave_mode ? preset_sel_a : preset_sel_b;

	nco_preset_bank #(
		.PRESETS(PRESETS),
		.PHASE_W(PHASE_W)
	) u_bank_a (
		.mclk(mclk),
		.reset_n(reset_n),
		.wr_en(reg_wr && hit_a),
		.rd_en(reg_rd && hit_a),
		.index(word_index),
		.wdata(reg_wdata),
		.sel(preset_sel_a),
		.rd_data_ff(rd_data_a),
		.act_freq(bank_freq[0]),
		.act_phase(bank_phase[0])
	);

	nco_preset_bank #(
		.PRESETS(PRESETS),
		.PHASE_W(PHASE_W)
	) u_bank_b (
		.mclk(mclk),
		.reset_n(reset_n),
		.wr_en(reg_wr && hit_b),
		.rd_en(reg_rd && hit_b),
		.index(word_index),
		.wdata(reg_wdata),
		.sel(sel_b_eff),
		.rd_data_ff(rd_data_b),
		.act_freq(bank_freq[1]),
		.act_phase(bank_phase[1])
	);

	// Unmapped addresses leave both banks idle, so they read as zero.
	assign reg_rdata = rd_data_a | rd_data_b;

	// ****************************************************************
	// Active preset per channel
	// ****************************************************************
	logic [31:0] act_freq [CHANNELS];
	logic [PHASE_W-1:0] act_phase [CHANNELS];

	// Interleaved mode drives channel B from the channel A bank, so the
	// two accumulators stay in step and B's stored presets have no effect.
	// ignore channel B presets
	always_comb begin
		act_freq[0] = bank_freq[0];
		act_phase[0] = bank_phase[0];
		if (interleave_mode) begin
			act_freq[1] = bank_freq[0];
			act_phase[1] = bank_phase[0];
		end else begin
			act_freq[1] = bank_freq[1];
			act_phase[1] = bank_phase[1];
		end
	end

	// ****************************************************************
	// Sysref synchronizer and edge detect
	// ****************************************************************
	logic sysref_meta_ff;
	logic sysref_sync_ff;
	logic sysref_prev_ff;
	logic sysref_rise;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sysref_meta_ff <= 1'b0;
			sysref_sync_ff <= 1'b0;
		end else begin
			sysref_meta_ff <= sysref;
			sysref_sync_ff <= sysref_meta_ff;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sysref_prev_ff <= 1'b0;
		end else begin
			sysref_prev_ff <= sysref_sync_ff;
		end
	end

	assign sysref_rise = sysref_sync_ff && !sysref_prev_ff;

	// ****************************************************************
	// Sync arming
	// ****************************************************************
	nco_pkg::sync_state_t sync_state_ff;
	nco_pkg::sync_state_t nxt_sync_state;
	logic sync_fire;
	logic sync_done_ff;

	// The arm level must be seen low before a high arms; a high left
	// standing after one initialization never arms a second time.
	// one-shot arming
	always_comb begin
		nxt_sync_state = sync_state_ff;
		sync_fire = 1'b0;
		unique case (sync_state_ff)
			nco_pkg::SYNC_IDLE: begin
				if (!sync_arm_bit) begin
					nxt_sync_state = nco_pkg::SYNC_PRIMED;
				end
			end
			nco_pkg::SYNC_PRIMED: begin
				if (sync_arm_bit) begin
					nxt_sync_state = nco_pkg::SYNC_ARMED;
				end
			end
			nco_pkg::SYNC_ARMED: begin
				if (!sync_arm_bit) begin
					nxt_sync_state = nco_pkg::SYNC_PRIMED;
				end else if (sysref_rise) begin
					nxt_sync_state = nco_pkg::SYNC_IDLE;
					sync_fire = 1'b1;
				end
			end
			default: begin
				nxt_sync_state = nco_pkg::SYNC_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sync_state_ff <= nco_pkg::SYNC_IDLE;
		end else begin
			sync_state_ff <= nxt_sync_state;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sync_done_ff <= 1'b0;
		end else begin
			sync_done_ff <= sync_fire;
		end
	end

	assign sync_armed = (sync_state_ff == nco_pkg::SYNC_ARMED);
	assign sync_done = sync_done_ff;

	// ****************************************************************
	// Phase accumulators
	// ****************************************************************
	logic [31:0] acc_ff [CHANNELS];
	logic [DIV_W-1:0] div_cnt_ff [CHANNELS];
	logic [31:0] phase_out_ff [CHANNELS];
	logic div_on;
	logic [DIV_W-1:0] div_last;

	assign div_on = (reference_divisor != `NCO_DIV_OFF);
	assign div_last = reference_divisor - `NCO_DIV_STEP;

	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
		logic div_wrap;

		assign div_wrap = div_on && (div_cnt_ff[ch] >= div_last);

		// With a divisor the tuning word is exact over divisor samples,
		// so the count restarts the accumulator on that period.
		// divisor period
		always_ff @(posedge mclk or negedge reset_n) begin
			if (!reset_n) begin
				div_cnt_ff[ch] <= `NCO_DIV_CNT_RST;
			end else if (sync_fire || !div_on || div_wrap) begin
				div_cnt_ff[ch] <= `NCO_DIV_CNT_RST;
			end else begin
				div_cnt_ff[ch] <= div_cnt_ff[ch] + `NCO_DIV_STEP;
			end
		end

		// A new tuning word is picked up on the next edge; the current
		// phase is kept, so the phase after the change is not realigned.
		// modulo accumulation
		always_ff @(posedge mclk or negedge reset_n) begin
			if (!reset_n) begin
				acc_ff[ch] <= `NCO_ACC_RST;
			end else if (sync_fire) begin
				acc_ff[ch] <= `NCO_ACC_RST;
			end else if (div_wrap) begin
				acc_ff[ch] <= `NCO_ACC_RST;
			end else begin
				acc_ff[ch] <= acc_ff[ch] + act_freq[ch];
			end
		end

		always_ff @(posedge mclk or negedge reset_n) begin
			if (!reset_n) begin
				phase_out_ff[ch] <= `NCO_ACC_RST;
			end else begin
				phase_out_ff[ch] <= acc_ff[ch] + {act_phase[ch], `NCO_PHASE_LOW_FILL};
			end
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign phase_a = phase_out_ff[0];
	assign phase_b = phase_out_ff[1];

endmodule

// ---- inc/nco_defines.svh ----
/*
 * Register offsets, reset values and field sizes of the oscillator preset set.
 * Assumes byte addresses on a 12-bit register port with one 32-bit word per register.
 */
`ifndef NCO_DEFINES_SVH
`define NCO_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define NCO_TUNE_WORD_A_P0_OFS 12'h220
`define NCO_PHASE_OFFSET_A_P0_OFS 12'h224
`define NCO_TUNE_WORD_A_P1_OFS 12'h228
`define NCO_PHASE_OFFSET_A_P1_OFS 12'h22C
`define NCO_TUNE_WORD_A_P2_OFS 12'h230
`define NCO_PHASE_OFFSET_A_P2_OFS 12'h234
`define NCO_TUNE_WORD_A_P3_OFS 12'h238
`define NCO_PHASE_OFFSET_A_P3_OFS 12'h23C
`define NCO_BANK_A_BASE 12'h220
`define NCO_BANK_B_BASE 12'h240
`define NCO_BANK_MASK 12'h01F

// ****************************************************************
// Reset values and fields
// ****************************************************************
`define NCO_TUNE_WORD_RST 32'hC000_0000
`define NCO_PHASE_OFFSET_RST 16'h0000
`define NCO_ACC_RST 32'h0000_0000
`define NCO_DIV_OFF 16'h0000
`define NCO_DIV_CNT_RST 16'h0000
`define NCO_DIV_STEP 16'h0001
`define NCO_PHASE_LOW_FILL 16'h0000
`define NCO_READ_IDLE 32'h0000_0000

`endif

// ---- inc/nco_pkg.sv ----
/*
 * Types shared by the oscillator preset set.
 * Assumes the defines header is compiled alongside.
 */
package nco_pkg;

	typedef logic [31:0] word_t;
	typedef logic [15:0] half_t;

	typedef enum logic {
		CHAN_A,
		CHAN_B
	} chan_t;

	typedef enum logic [1:0] {
		SYNC_IDLE,
		SYNC_PRIMED,
		SYNC_ARMED
	} sync_state_t;

endpackage

// ---- hdl/nco_preset_bank.sv ----
/*
 * One channel's preset bank: tuning words and phase offsets with register access.
 * Assumes the owner decodes the bank and gives a word index: even is tuning, odd is phase.
 */
`include "nco_defines.svh"

module nco_preset_bank #(
	parameter int PRESETS = 4,
	parameter int PHASE_W = 16
) (
	input wire logic mclk, // Sample clock.
	input wire logic reset_n, // Asynchronous reset, active low.
	input wire logic wr_en, // Write strobe for this bank.
	input wire logic rd_en, // Read strobe for this bank.
	input wire logic [$clog2(PRESETS):0] index, // Word index inside the bank.
	input wire logic [31:0] wdata, // Write data.
	input wire logic [$clog2(PRESETS)-1:0] sel, // Active preset.
	output logic [31:0] rd_data_ff, // Read data, valid the cycle after rd_en.
	output logic [31:0] act_freq, // Tuning word of the active preset.
	output logic [PHASE_W-1:0] act_phase // Phase offset of the active preset.
);

	localparam int SW = $clog2(PRESETS);

	logic [31:0] freq_ff [PRESETS];
	logic [PHASE_W-1:0] phase_ff [PRESETS];
	logic [SW-1:0] slot;
	logic is_phase;

	assign slot = index[SW:1];
	assign is_phase = index[0];

	// ****************************************************************
	// Preset storage
	// ****************************************************************
	// tuning word reset
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < PRESETS; i++) begin
				freq_ff[i] <= `NCO_TUNE_WORD_RST;
				phase_ff[i] <= `NCO_PHASE_OFFSET_RST;
			end
		end else if (wr_en) begin
			if (is_phase) begin
				phase_ff[slot] <= wdata[PHASE_W-1:0];
			end else begin
				freq_ff[slot] <= wdata;
			end
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	// paired register readback
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data_ff <= `NCO_READ_IDLE;
		end else if (rd_en) begin
			rd_data_ff <= is_phase ? {{(32-PHASE_W){1'b0}}, phase_ff[slot]} : freq_ff[slot];
		end else begin
			rd_data_ff <= `NCO_READ_IDLE;
		end
	end

	assign act_freq = freq_ff[sel];
	assign act_phase = phase_ff[sel];

endmodule

// ---- testbench/nco_preset_freq_phase_properties.sv ----
/*
 * Checker of the oscillator preset set, watching the top ports only.
 * Assumes one clock domain; bound to every instance of the block below.
 */
module nco_preset_freq_phase_properties #(
	parameter int PRESETS = 4,
	parameter int PHASE_W = 16,
	parameter int DIV_W = 16
) (
	input wire logic mclk, // Clock.
	input wire logic reset_n, // Reset.
	input wire logic [11:0] reg_addr, // Address.
	input wire logic [31:0] reg_wdata, // Write data.
	input wire logic reg_wr, // Write strobe.
	input wire logic reg_rd, // Read strobe.
	input wire logic [31:0] reg_rdata, // Read data.
	input wire logic interleave_mode, // Interleave.
	input wire logic [$clog2(PRESETS)-1:0] preset_sel_a, // Preset A.
	input wire logic [$clog2(PRESETS)-1:0] preset_sel_b, // Preset B.
	input wire logic [DIV_W-1:0] reference_divisor, // Divisor.
	input wire logic sync_arm_bit, // Arm level.
	input wire logic sysref, // Sysref pin.
	input wire logic [31:0] phase_a, // Phase A.
	input wire logic [31:0] phase_b, // Phase B.
	input wire logic sync_armed, // Armed.
	input wire logic sync_done // Sync pulse.
);
	// ************
	// Properties
	// ************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	rdata_idle_a: assert property (
		$past(reg_rd) == 1'b0 |-> reg_rdata == 32'h0000_0000)
		else $error("read data not zero outside the read cycle");
	unmapped_zero_a: assert property (
		reg_rd && (reg_addr < 12'h220 || reg_addr > 12'h25C || reg_addr[1:0] != 2'h0)
		|=> reg_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	phase_upper_a: assert property (
		reg_rd && reg_addr[2] |=> reg_rdata[31:16] == 16'h0000)
		else $error("phase read upper half not zero");
	step_steady_a: assert property (
		(!reg_wr && $stable(preset_sel_a) && reference_divisor == '0 && !sync_armed)[*4]
		|-> phase_a - $past(phase_a) == $past(phase_a) - $past(phase_a, 2))
		else $error("channel A phase step not constant");
	interleave_follow_a: assert property (
		(interleave_mode && reference_divisor == '0 && !sync_armed)[*4]
		|-> phase_b - $past(phase_b) == phase_a - $past(phase_a))
		else $error("channel B step differs in interleave");
	arm_sequence_a: assert property (
		!sysref[*2] ##1 (!sync_arm_bit && !sysref) ##1 (sync_arm_bit && !sysref)[*4]
		|-> sync_armed)
		else $error("arm low then high did not arm");
	done_pulse_a: assert property (
		sync_done |-> (!sync_armed && ($past(sync_armed) || $past(sync_armed, 2)))
		##1 !sync_done)
		else $error("sync pulse without arming or too long");
	idle_no_fire_a: assert property (
		!sync_armed[*3] |=> !sync_done)
		else $error("sync fired while not armed");
endmodule

bind nco_preset_freq_phase nco_preset_freq_phase_properties #(
	.PRESETS(PRESETS),
	.PHASE_W(PHASE_W),
	.DIV_W(DIV_W)
) chk_i (
	.mclk(mclk),
	.reset_n(reset_n),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.interleave_mode(interleave_mode),
	.preset_sel_a(preset_sel_a),
	.preset_sel_b(preset_sel_b),
	.reference_divisor(reference_divisor),
	.sync_arm_bit(sync_arm_bit),
	.sysref(sysref),
	.phase_a(phase_a),
	.phase_b(phase_b),
	.sync_armed(sync_armed),
	.sync_done(sync_done)
);

// ---- testbench/nco_preset_freq_phase_tb_top.sv ----
/*
 * Self-checking bench of the oscillator preset set: registers, presets, sync.
 * Assumes the checker file is compiled alongside and binds itself.
 */
module nco_preset_freq_phase_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic interleave_mode = 1'b0;
	logic [1:0] preset_sel_a = 2'h0;
	logic [1:0] preset_sel_b = 2'h0;
	logic [15:0] reference_divisor = 16'h0000;
	logic sync_arm_bit = 1'b0;
	logic sysref = 1'b0;
	logic [31:0] phase_a;
	logic [31:0] phase_b;
	logic sync_armed;
	logic sync_done;
	logic rd_d = 1'b0;
	logic [31:0] exp_q[$];
	logic [31:0] seed = 32'h0001_0BEB;
	int errors = 0;
	int comparisons = 0;
	int cyc = 0;

	always #25 mclk = ~mclk;

	nco_preset_freq_phase uut (
		.mclk(mclk),
		.reset_n(reset_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.interleave_mode(interleave_mode),
		.preset_sel_a(preset_sel_a),
		.preset_sel_b(preset_sel_b),
		.reference_divisor(reference_divisor),
		.sync_arm_bit(sync_arm_bit),
		.sysref(sysref),
		.phase_a(phase_a),
		.phase_b(phase_b),
		.sync_armed(sync_armed),
		.sync_done(sync_done)
	);

	// ************
	// Helpers
	// ************
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		if (errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// For a read, d is the value expected back one cycle later.
	task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		if (r) begin
			exp_q.push_back(d);
		end
	endtask

	always @(posedge mclk) begin
		if (rd_d) begin
			chk(reg_rdata, exp_q.pop_front());
		end
		rd_d <= reg_rd;
		cyc++;
		if (cyc == 2000) begin
			errors++;
			summarize();
		end
	end

	// ************
	// Sequence
	// ************
	initial begin
		logic [31:0] wa;
		logic [31:0] wb;
		logic [31:0] oa;
		logic [31:0] ob;
		logic [1:0] k;
		logic il;
		int n;
		int m;
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			bus(1'b0, 1'b1, 12'h220 + 12'(4 * i), i[0] ? 32'h0000_0000 : 32'hC000_0000);
		end
		bus(1'b1, 1'b0, 12'h222, xs());
		bus(1'b1, 1'b0, 12'h260, xs());
		bus(1'b0, 1'b1, 12'h222, 32'h0000_0000);
		bus(1'b0, 1'b1, 12'h260, 32'h0000_0000);
		bus(1'b0, 1'b1, 12'h220, 32'hC000_0000);
		for (int i = 0; i < 16; i++) begin
			wa = xs();
			bus(1'b1, 1'b0, 12'h220 + 12'(4 * i), wa);
			bus(1'b0, 1'b1, 12'h220 + 12'(4 * i), i[0] ? {16'h0000, wa[15:0]} : wa);
		end
		// Last pass runs interleaved, with channel B pointed at another preset.
		for (int it = 0; it < 5; it++) begin
			k = it[1:0];
			il = (it == 4);
			// Pass 3 sets the divisor first, then the word, and restarts every three samples.
			reference_divisor <= (it == 3) ? 16'h0003 : 16'h0000;
			wa = xs();
			wa[31] = it[0];
			wb = xs();
			oa = xs();
			ob = xs();
			bus(1'b1, 1'b0, 12'h220 + {7'h00, k, 3'h0}, wa);
			bus(1'b1, 1'b0, 12'h224 + {7'h00, k, 3'h0}, oa);
			bus(1'b1, 1'b0, 12'h240 + {7'h00, k, 3'h0}, wb);
			bus(1'b1, 1'b0, 12'h244 + {7'h00, k, 3'h0}, ob);
			bus(1'b0, 1'b0, 12'h000, 32'h0000_0000);
			preset_sel_a <= k;
			preset_sel_b <= il ? ~k : k;
			interleave_mode <= il;
			sync_arm_bit <= 1'b0;
			repeat (3) @(posedge mclk);
			sync_arm_bit <= 1'b1;
			repeat (6) @(posedge mclk);
			chk({31'h0000_0000, sync_armed}, 32'h0000_0001);
			sysref <= 1'b1;
			n = 0;
			do begin
				@(negedge mclk);
				n++;
			end while (sync_done !== 1'b1 && n < 12);
			chk({31'h0000_0000, sync_done}, 32'h0000_0001);
			// A second rise without re-arming must leave the phase running on.
			for (n = 0; n < 12; n++) begin
				@(posedge mclk);
				if (n == 1) sysref <= 1'b0;
				if (n == 3) sysref <= 1'b1;
				@(negedge mclk);
				m = (it == 3) ? n % 3 : n;
				chk(phase_a, wa * m + {oa[15:0], 16'h0000});
				chk(phase_b, il ? wa * m + {oa[15:0], 16'h0000} : wb * m + {ob[15:0], 16'h0000});
			end
			@(posedge mclk);
			sysref <= 1'b0;
		end
		repeat (2) @(posedge mclk);
		summarize();
	end
endmodule
